// *** wdpc_top.v ***
// Prescaled 8-bit watchdog / general timer with register port
//
// Contract
// R1 - Watchdog reset disabled after power-up and external resets
// R2 - Reset enable is bit 0 of config
// R3 - Only first reset-enable write is accepted
// R4 - Counter readable and writable at 0CE
// R5 - Software writes n-1 for n counts
// R6 - Counter write presets prescaler FF, starts
// R7 - Armed underflow resets device, stays armed
// R8 - Underflow stops prescaler and counter
// R9 - HALT entry presets FF, clears expiry flag
// R10 - Crystal wakeup reuses counters, contents altered
// R11 - Unarmed underflow only sets expiry flag
// R12 - Counter write sets hidden running flag
// R13 - Running flag cleared by all resets
// R14 - Watchdog reset presets FF, clears running
// R15 - External/brownout reset presets FF, clears all
// R16 - Expiry flag is read-only status bit
// R17 - Expiry cleared by resets, write, HALT; the watchdog reset sets it instead
// R18 - Software services counter before underflow
// R19 - Crystal wakeup holds chip for 256 cycles
// R20 - Prescaler ticks at oscillator divided by ten
// R21 - Prescaler wrap decrements counter; underflow below zero
//
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "wdpc_consts.vh"
module wdpc_top
#(
   parameter TC_DIV = `WDPC_TC_DIV
)
(
   // Clock and reset
   input  wire       clock_in,
   input  wire       rst_n_in,
   // Chip events
   input  wire       brownout_reset_in,
   input  wire       halt_enter_in,
   input  wire       xtal_wakeup_in,
   // Register port
   input  wire [7:0] addr_in,
   input  wire [7:0] wdata_in,
   input  wire       wr_in,
   input  wire       rd_in,
   output reg  [7:0] rdata_out,
   // Chip-level outputs
   output reg        wd_reset_out,
   output reg        clock_hold_out,
   output reg        expiry_flag_out
);

   // Run states
   localparam ST_IDLE  = 2'b00;
   localparam ST_RUN   = 2'b01;
   localparam ST_WAKE  = 2'b10;

   // Counting datapath and run state
   reg  [1:0] state_r;
   reg  [1:0] state_nxt;
   reg  [7:0] presc_r;
   reg  [7:0] presc_nxt;
   reg  [7:0] count_r;
   reg  [7:0] count_nxt;

   // Reset-enable, its write-once lock and the flags
   reg        rst_en_r;
   reg        rst_en_nxt;
   reg        rst_en_locked_r;
   reg        rst_en_locked_nxt;
   reg        expiry_r;
   reg        expiry_nxt;
   reg        running_r;
   reg        running_nxt;

   // Length of the outgoing reset request
   reg  [2:0] wdrst_cnt_r;
   reg  [2:0] wdrst_cnt_nxt;

   // Pin synchronisers; the first stage feeds no logic, the edge delays follow the second
   reg        bor_s1_r;
   reg        bor_s2_r;
   reg        halt_s1_r;
   reg        halt_s2_r;
   reg        halt_d_r;
   reg        wake_s1_r;
   reg        wake_s2_r;
   reg        wake_d_r;

   // Decoded events and strobes
   wire       tick;
   wire       ext_reset;
   wire       halt_rise;
   wire       wake_rise;
   wire       cnt_wr;
   wire       cfg_wr;
   wire       wd_fire;
   reg        underflow;

   // True when prescaler wraps and counter is at zero
   function is_underflow;
      input [7:0] p;
      input [7:0] c;
      begin
         is_underflow = (p == 8'h00) && (c == 8'h00);
      end
   endfunction

   // Instruction-cycle tick, free-running from reset
   wdpc_tc_div
   #(
      .DIV      (TC_DIV)
   )
   u_div
   (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .tick_out (tick)
   );

   // Pin-level events pass two flops first
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         bor_s1_r  <= 1'b0;
         bor_s2_r  <= 1'b0;
         halt_s1_r <= 1'b0;
         halt_s2_r <= 1'b0;
         halt_d_r  <= 1'b0;
         wake_s1_r <= 1'b0;
         wake_s2_r <= 1'b0;
         wake_d_r  <= 1'b0;
      end
      else
      begin
         bor_s1_r  <= brownout_reset_in;
         bor_s2_r  <= bor_s1_r;
         halt_s1_r <= halt_enter_in;
         halt_s2_r <= halt_s1_r;
         halt_d_r  <= halt_s2_r;
         wake_s1_r <= xtal_wakeup_in;
         wake_s2_r <= wake_s1_r;
         wake_d_r  <= wake_s2_r;
      end
   end

   // Brown-out level and event edges after the synchronisers, and decoded write strobes
   assign ext_reset = bor_s2_r;
   assign halt_rise = halt_s2_r & ~halt_d_r;
   assign wake_rise = wake_s2_r & ~wake_d_r;
   assign cnt_wr    = wr_in && (addr_in == `WDPC_ADDR_COUNT);
   assign cfg_wr    = wr_in && (addr_in == `WDPC_ADDR_CONFIG);

   // Armed expiry fires only while a started count runs
   assign wd_fire   = underflow && rst_en_r && running_r && (state_r == ST_RUN); // see R7

   // Next-state logic; later branches win, so the order is
   // ext reset > wd reset > wakeup > halt > writes > counting
   always @*
   begin
      state_nxt         = state_r;
      presc_nxt         = presc_r;
      count_nxt         = count_r;
      rst_en_nxt        = rst_en_r;
      rst_en_locked_nxt = rst_en_locked_r;
      expiry_nxt        = expiry_r;
      running_nxt       = running_r;
      wdrst_cnt_nxt     = (wdrst_cnt_r != 3'd0) ? wdrst_cnt_r - 3'd1 : 3'd0;
      underflow         = tick && is_underflow(presc_r, count_r); // see R21

      // Counting serves both software timing and the start-up hold
      if (state_r == ST_RUN || state_r == ST_WAKE)
      begin
         if (tick)
         begin
            presc_nxt = presc_r - 8'h01; // see R21
            if (presc_r == 8'h00)
               count_nxt = count_r - 8'h01; // see R21
         end
         // One prescaler pass of 256 ticks is the whole hold; waiting
         // for the counter as well would hold for 65536 ticks
         if (state_r == ST_WAKE && tick && presc_r == 8'h00)
            state_nxt = ST_IDLE; // see R19
         if (underflow)
         begin
            state_nxt = ST_IDLE; // see R8
            presc_nxt = 8'h00;
            count_nxt = 8'h00;
            if (state_r == ST_RUN)
               expiry_nxt = 1'b1; // see R11 see R16
         end
      end

      // Counter write restarts timing and clears the expiry flag
      if (cnt_wr)
      begin
         count_nxt   = wdata_in; // see R4 see R5
         presc_nxt   = `WDPC_PRESET; // see R6
         state_nxt   = ST_RUN; // see R6
         running_nxt = 1'b1; // see R12
         expiry_nxt  = 1'b0; // see R17
      end

      // Reset-enable takes the first write only, until an external reset
      if (cfg_wr && !rst_en_locked_r)
      begin
         rst_en_nxt        = wdata_in[`WDPC_BIT_RST_EN]; // see R2
         rst_en_locked_nxt = 1'b1; // see R3
      end

      // HALT entry leaves reset-enable and the running flag alone
      if (halt_rise)
      begin
         presc_nxt  = `WDPC_PRESET; // see R9
         count_nxt  = `WDPC_PRESET;
         expiry_nxt = 1'b0; // see R17
         state_nxt  = ST_IDLE;
      end

      // Crystal wakeup presets both stages and holds the core clock
      if (wake_rise)
      begin
         presc_nxt = `WDPC_PRESET; // see R10 see R19
         count_nxt = `WDPC_PRESET;
         state_nxt = ST_WAKE;
      end

      // Watchdog reset keeps the block armed and the expiry flag set
      if (wd_fire)
      begin
         presc_nxt     = `WDPC_PRESET; // see R14
         count_nxt     = `WDPC_PRESET;
         running_nxt   = 1'b0; // see R13
         state_nxt     = ST_IDLE;
         expiry_nxt    = 1'b1;
         wdrst_cnt_nxt = `WDPC_WD_RST_CYCLES;
      end

      // External or brown-out reset clears all that software set
      if (ext_reset)
      begin
         presc_nxt         = `WDPC_PRESET; // see R15
         count_nxt         = `WDPC_PRESET;
         rst_en_nxt        = 1'b0; // see R1
         rst_en_locked_nxt = 1'b0;
         expiry_nxt        = 1'b0; // see R17
         running_nxt       = 1'b0; // see R13
         state_nxt         = ST_IDLE;
         wdrst_cnt_nxt     = 3'd0;
      end
   end

   // State registers; external reset pin acts like brown-out
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         state_r         <= ST_IDLE;
         presc_r         <= `WDPC_PRESET; // see R15
         count_r         <= `WDPC_PRESET;
         rst_en_r        <= 1'b0; // see R1
         rst_en_locked_r <= 1'b0;
         expiry_r        <= 1'b0;
         running_r       <= 1'b0; // see R13
         wdrst_cnt_r     <= 3'd0;
      end
      else
      begin
         state_r         <= state_nxt;
         presc_r         <= presc_nxt;
         count_r         <= count_nxt;
         rst_en_r        <= rst_en_nxt;
         rst_en_locked_r <= rst_en_locked_nxt;
         expiry_r        <= expiry_nxt;
         running_r       <= running_nxt;
         wdrst_cnt_r     <= wdrst_cnt_nxt;
      end
   end

   // Registered outputs and read data, one cycle after the strobe
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         rdata_out       <= 8'h00;
         wd_reset_out    <= 1'b0;
         clock_hold_out  <= 1'b0;
         expiry_flag_out <= 1'b0;
      end
      else
      begin
         wd_reset_out    <= (wdrst_cnt_nxt != 3'd0); // see R7
         clock_hold_out  <= (state_nxt == ST_WAKE); // see R19
         expiry_flag_out <= expiry_nxt;
         rdata_out       <= 8'h00;
         if (rd_in)
         begin
            case (addr_in)
               `WDPC_ADDR_COUNT:  rdata_out <= count_r; // see R4
               `WDPC_ADDR_CONFIG: rdata_out <= {7'h00, rst_en_r};
               `WDPC_ADDR_STATUS: rdata_out <= {7'h00, expiry_r}; // see R16
               default:           rdata_out <= 8'h00;
            endcase
         end
      end
   end

endmodule

// *** wdpc_consts.vh ***
// Constants for the prescaled watchdog counter block
`ifndef WDPC_CONSTS_VH
`define WDPC_CONSTS_VH
`define WDPC_ADDR_W          8
`define WDPC_ADDR_COUNT      8'hCE
`define WDPC_ADDR_CONFIG     8'hCD
`define WDPC_ADDR_STATUS     8'hCC
`define WDPC_BIT_RST_EN      0
`define WDPC_BIT_EXPIRY      0
`define WDPC_PRESET          8'hFF
`define WDPC_TC_DIV          10
`define WDPC_WD_RST_CYCLES   3'h4
`endif

// *** wdpc_tc_div.v ***
// Instruction-cycle tick generator dividing the core clock
`timescale 1ns/10ps
module wdpc_tc_div
#(
   parameter DIV = 10
)
(
   // Clock and reset
   input  wire       clock_in,
   input  wire       rst_n_in,
   // Tick output
   output reg        tick_out
);

   reg  [7:0] cnt_r;

   // One tick per DIV clocks
   always @(posedge clock_in)
   begin
      if (!rst_n_in)
      begin
         cnt_r    <= 8'h00;
         tick_out <= 1'b0;
      end
      else if ({24'h000000, cnt_r} == DIV - 32'h00000001)
      begin
         cnt_r    <= 8'h00;
         tick_out <= 1'b1; // see R20
      end
      else
      begin
         cnt_r    <= cnt_r + 8'h01;
         tick_out <= 1'b0;
      end
   end

endmodule

// *** wdpc_properties.sv ***
// Concurrent checks on the prescaled watchdog counter ports
`timescale 1ns/10ps
`include "wdpc_consts.vh"
module wdpc_properties
#(
   parameter TC_DIV = 10
)
(
   input wire       clock_in,
   input wire       rst_n_in,
   input wire       brownout_reset_in,
   input wire       halt_enter_in,
   input wire       xtal_wakeup_in,
   input wire [7:0] addr_in,
   input wire [7:0] wdata_in,
   input wire       wr_in,
   input wire       rd_in,
   input wire [7:0] rdata_out,
   input wire       wd_reset_out,
   input wire       clock_hold_out,
   input wire       expiry_flag_out
);
   // Length of the current start-up hold, in clocks
   logic [15:0] hold_cnt_r;
   always_ff @(posedge clock_in)
      if (!rst_n_in || !clock_hold_out)
         hold_cnt_r <= 16'h0;
      else
         hold_cnt_r <= hold_cnt_r + 16'h1;
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_n_in);
   // Reset request is a fixed pulse, then drops
   sequence rst_pulse;
      wd_reset_out [*4] ##1 !wd_reset_out;
   endsequence
   chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
      else $error("read data not zero outside read");
   chk_rst_len: assert property ($rose(wd_reset_out) |-> rst_pulse)
      else $error("reset pulse length wrong");
   chk_rst_flag: assert property ($rose(wd_reset_out) |-> ##[0:2] expiry_flag_out)
      else $error("expiry flag missing at reset");
   chk_bor_clear: assert property (brownout_reset_in [*4] |-> !expiry_flag_out)
      else $error("brownout left expiry set");
   chk_halt_clear: assert property ($rose(halt_enter_in) |-> ##[1:5] !expiry_flag_out)
      else $error("halt entry left expiry set");
   chk_status_ro: assert property (
      wr_in && addr_in == `WDPC_ADDR_STATUS && expiry_flag_out |=> expiry_flag_out)
      else $error("status write changed expiry");
   chk_hold_cause: assert property ($rose(clock_hold_out) |-> $past(xtal_wakeup_in, 2))
      else $error("hold without wakeup");
   chk_hold_len: assert property (
      $fell(clock_hold_out) |->
      $past(hold_cnt_r) >= 254 * TC_DIV && $past(hold_cnt_r) <= 258 * TC_DIV)
      else $error("start-up hold length wrong");
   chk_count_wr: assert property (
      wr_in && addr_in == `WDPC_ADDR_COUNT && !wd_reset_out |=> !expiry_flag_out)
      else $error("count write left expiry set");
endmodule

bind wdpc_top wdpc_properties #(.TC_DIV(TC_DIV)) u_props (.clock_in(clock_in),
   .rst_n_in(rst_n_in), .brownout_reset_in(brownout_reset_in),
   .halt_enter_in(halt_enter_in), .xtal_wakeup_in(xtal_wakeup_in), .addr_in(addr_in),
   .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .wd_reset_out(wd_reset_out), .clock_hold_out(clock_hold_out),
   .expiry_flag_out(expiry_flag_out));

// *** wdpc_top_tb.sv ***
// Directed register-level tests for the prescaled watchdog counter
`timescale 1ns/10ps
`include "wdpc_consts.vh"
module wdpc_top_tb;
   localparam DIV = 2; // Short tick keeps 256-tick runs brief
   logic       clock_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic       brownout_reset_in = 1'b0;
   logic       halt_enter_in = 1'b0;
   logic       xtal_wakeup_in = 1'b0;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic       wr_in = 1'b0;
   logic       rd_in = 1'b0;
   wire  [7:0] rdata_out;
   wire        wd_reset_out;
   wire        clock_hold_out;
   wire        expiry_flag_out;
   logic       seen_rst = 1'b0;
   int         mismatches = 0;
   int         n_compared = 0;
   always #20 clock_in = ~clock_in;
   wdpc_top #(.TC_DIV(DIV)) uut (.clock_in(clock_in), .rst_n_in(rst_n_in),
      .brownout_reset_in(brownout_reset_in), .halt_enter_in(halt_enter_in),
      .xtal_wakeup_in(xtal_wakeup_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .wd_reset_out(wd_reset_out),
      .clock_hold_out(clock_hold_out), .expiry_flag_out(expiry_flag_out));
   // Remember any reset request, timer mode must never raise one
   always @(posedge clock_in)
      if (wd_reset_out === 1'b1)
         seen_rst <= 1'b1;
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 check(rdata_out, exp);
   endtask
   // Bounded wait; a timeout shows up in the following check
   task automatic wait_bit(input int sel, input logic lvl);
      int n;
      n = 0;
      while ((sel == 0 ? expiry_flag_out : sel == 1 ? wd_reset_out : clock_hold_out) !== lvl
         && n < 800)
      begin
         @(posedge clock_in);
         n++;
      end
   endtask
   // Event pin high for 8 clocks: 0 selects HALT entry, else brown-out
   task automatic pulse(input int sel);
      @(posedge clock_in);
      if (sel == 0)
         halt_enter_in <= 1'b1;
      else
         brownout_reset_in <= 1'b1;
      repeat (8) @(posedge clock_in);
      halt_enter_in <= 1'b0;
      brownout_reset_in <= 1'b0;
      repeat (4) @(posedge clock_in);
   endtask
   task automatic conclude;
      $display("Compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Watchdog against a hung run
   initial
   begin
      #800000;
      mismatches++;
      conclude();
   end
   initial
   begin
      repeat (10) @(posedge clock_in);
      rst_n_in <= 1'b1;
      rdc(`WDPC_ADDR_COUNT, 8'hFF);
      rdc(`WDPC_ADDR_CONFIG, 8'h00);
      rdc(`WDPC_ADDR_STATUS, 8'h00);
      rdc(8'h10, 8'h00);
      wr(`WDPC_ADDR_COUNT, 8'h05);
      rdc(`WDPC_ADDR_COUNT, 8'h05);
      wr(`WDPC_ADDR_COUNT, 8'h00);
      wait_bit(0, 1'b1);
      check(expiry_flag_out, 8'h01);
      repeat (600) @(posedge clock_in);
      check(seen_rst, 8'h00);
      rdc(`WDPC_ADDR_COUNT, 8'h00);
      wr(`WDPC_ADDR_STATUS, 8'h00);
      rdc(`WDPC_ADDR_STATUS, 8'h01);
      wr(`WDPC_ADDR_COUNT, 8'h07);
      rdc(`WDPC_ADDR_STATUS, 8'h00);
      wr(`WDPC_ADDR_COUNT, 8'h01);
      repeat (600) @(posedge clock_in);
      check(expiry_flag_out, 8'h00);
      wait_bit(0, 1'b1);
      check(expiry_flag_out, 8'h01);
      pulse(0);
      rdc(`WDPC_ADDR_STATUS, 8'h00);
      rdc(`WDPC_ADDR_COUNT, 8'hFF);
      wr(`WDPC_ADDR_CONFIG, 8'h01);
      wr(`WDPC_ADDR_CONFIG, 8'h00);
      rdc(`WDPC_ADDR_CONFIG, 8'h01);
      repeat (3)
      begin
         wr(`WDPC_ADDR_COUNT, 8'h00);
         repeat (400) @(posedge clock_in);
      end
      check(seen_rst, 8'h00);
      wr(`WDPC_ADDR_COUNT, 8'h00);
      wait_bit(1, 1'b1);
      check(wd_reset_out, 8'h01);
      repeat (6) @(posedge clock_in);
      rdc(`WDPC_ADDR_CONFIG, 8'h01);
      rdc(`WDPC_ADDR_STATUS, 8'h01);
      rdc(`WDPC_ADDR_COUNT, 8'hFF);
      pulse(1);
      rdc(`WDPC_ADDR_CONFIG, 8'h00);
      rdc(`WDPC_ADDR_STATUS, 8'h00);
      wr(`WDPC_ADDR_CONFIG, 8'h00);
      wr(`WDPC_ADDR_CONFIG, 8'h01);
      rdc(`WDPC_ADDR_CONFIG, 8'h00);
      @(posedge clock_in);
      xtal_wakeup_in <= 1'b1;
      wait_bit(2, 1'b1);
      check(clock_hold_out, 8'h01);
      xtal_wakeup_in <= 1'b0;
      wait_bit(2, 1'b0);
      check(clock_hold_out, 8'h00);
      rdc(`WDPC_ADDR_COUNT, 8'hFE);
      conclude();
   end
endmodule
